// ### hdl/ida_pkg.sv
package ida_pkg;

  // ------------------------------------------------------------------
  // Widths and encodings
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned OPND_W     = 16;
  localparam int unsigned BCD_DIGITS = 4;

  localparam logic SIZE_BYTE = 1'b0;
  localparam logic SIZE_WORD = 1'b1;

  localparam logic [1:0] WID_8  = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;

  // Flag register bit positions.
  localparam logic [2:0] FLAG_C_POS = 3'h0;
  localparam logic [2:0] FLAG_D_POS = 3'h1;
  localparam logic [2:0] FLAG_Z_POS = 3'h2;
  localparam logic [2:0] FLAG_S_POS = 3'h3;
  localparam logic [2:0] FLAG_B_POS = 3'h4;
  localparam logic [2:0] FLAG_O_POS = 3'h5;
  localparam logic [2:0] FLAG_I_POS = 3'h6;
  localparam logic [2:0] FLAG_U_POS = 3'h7;

  localparam logic [7:0]        FLAGS_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    ida_magnitude_op                  = 4'h0,
    ida_sum_with_carry_op             = 4'h1,
    ida_carry_only_increment_op       = 4'h2,
    ida_plain_sum_op                  = 4'h3,
    ida_extended_sum_op               = 4'h4,
    ida_range_limit_op                = 4'h5,
    ida_compare_op                    = 4'h6,
    ida_extended_compare_op           = 4'h7,
    ida_bcd_sum_with_carry_op         = 4'h8,
    ida_bcd_sum_op                    = 4'h9,
    ida_bcd_difference_with_borrow_op = 4'hA,
    ida_signed_quotient_op            = 4'hB,
    ida_unsigned_quotient_op          = 4'hC,
    ida_signed_quotient_alt_op        = 4'hD,
    ida_flag_bit_write_op             = 4'hE
  } ida_op_t;

  typedef struct packed {
    logic u;
    logic i;
    logic o;
    logic b;
    logic s;
    logic z;
    logic d;
    logic c;
  } ida_flags_t;

  typedef struct packed {
    ida_op_t           op;
    logic              size;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] src2;
    logic [DATA_W-1:0] dest;
    logic [OPND_W-1:0] high_result_register;
    logic [OPND_W-1:0] low_result_register;
    logic [2:0]        bit_index;
    logic              bit_value;
  } ida_req_t;

  typedef enum logic [1:0] {
    ida_st_idle     = 2'b00,
    ida_st_div_wait = 2'b01
  } ida_state_t;

endpackage

// ### hdl/ida_bcd.sv
`timescale 1ns/1ps

module ida_bcd #(
  parameter int unsigned DIGITS = ida_pkg::BCD_DIGITS
) (
  input  wire logic [4*DIGITS-1:0] a_i,     // Minuend or first addend
  input  wire logic [4*DIGITS-1:0] b_i,     // Subtrahend or second addend
  input  wire logic                cin_i,   // Carry or borrow into digit 0
  input  wire logic                sub_i,   // High for subtraction
  output logic      [4*DIGITS-1:0] sum_o,   // Packed decimal result
  output logic      [DIGITS-1:0]   carry_o  // Carry or borrow out of each digit
);

  logic [DIGITS:0] chain;

  assign chain[0] = cin_i;

  // ------------------------------------------------------------------
  // One digit per stage
  // ------------------------------------------------------------------
  for (genvar g = 0; g < DIGITS; g++) begin : g_digit
    logic [4:0] raw;
    logic [3:0] digit;
    logic       cout;
    always_comb begin
      raw   = 5'h00;
      digit = 4'h0;
      cout  = 1'b0;
      if (sub_i) begin
        raw  = {1'b0, a_i[4*g +: 4]} - {1'b0, b_i[4*g +: 4]} - {4'h0, chain[g]};
        cout = raw[4];
        // A negative digit wraps by ten, which mod sixteen is minus six.
        digit = raw[4] ? (raw[3:0] - 4'h6) : raw[3:0];
      end else begin
        raw   = {1'b0, a_i[4*g +: 4]} + {1'b0, b_i[4*g +: 4]} + {4'h0, chain[g]};
        cout  = (raw > 5'h09);
        digit = cout ? (raw[3:0] + 4'h6) : raw[3:0];
      end
    end
    assign chain[g+1]        = cout;
    assign sum_o[4*g +: 4]   = digit;
    assign carry_o[g]        = cout;
  end

endmodule

// ### hdl/ida_divider.sv
`timescale 1ns/1ps

module ida_divider #(
  parameter int unsigned DW = ida_pkg::OPND_W
) (
  input  wire logic            clk_i,        // Core clock
  input  wire logic            rst_b_i,      // Asynchronous reset, active low
  input  wire logic            start_i,      // One-cycle start pulse
  input  wire logic            signed_i,     // Treat operands as two's complement
  input  wire logic            alt_i,        // Remainder takes the divisor's sign
  input  wire logic [2*DW-1:0] dividend_i,   // Extended dividend
  input  wire logic [DW-1:0]   divisor_i,    // Extended divisor
  output logic                 done_o,       // One-cycle result pulse
  output logic                 zero_div_o,   // Divisor was zero
  output logic      [2*DW-1:0] quotient_o,   // Full-width quotient
  output logic      [DW-1:0]   remainder_o   // Remainder
);

  localparam int unsigned CW = $clog2(2 * DW) + 1;
  localparam logic [CW-1:0] LAST_STEP = CW'(2 * DW - 1);

  logic [2*DW-1:0] quo;
  logic [DW-1:0]   rem;
  logic [DW-1:0]   dsr;
  logic [CW-1:0]   step;
  logic            run;
  logic            fix;
  logic            neg_q;
  logic            neg_r;
  logic            neg_d;
  logic            alt;
  logic            zero;
  logic [DW:0]     shifted;
  logic            fits;
  logic [2*DW-1:0] q_s;
  logic [DW-1:0]   r_s;

  assign shifted = {rem, quo[2*DW-1]};
  assign fits    = (shifted >= {1'b0, dsr});

  // ------------------------------------------------------------------
  // Restoring division on magnitudes, one quotient bit per cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quo   <= '0;
      rem   <= '0;
      dsr   <= '0;
      step  <= '0;
      run   <= 1'b0;
      fix   <= 1'b0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      neg_d <= 1'b0;
      alt   <= 1'b0;
      zero  <= 1'b0;
    end else begin
      fix <= 1'b0;
      if (start_i && !run && !fix) begin
        neg_r <= signed_i && dividend_i[2*DW-1];
        neg_d <= signed_i && divisor_i[DW-1];
        neg_q <= signed_i && (dividend_i[2*DW-1] ^ divisor_i[DW-1]);
        alt   <= alt_i;
        quo   <= (signed_i && dividend_i[2*DW-1]) ? -dividend_i : dividend_i;
        dsr   <= (signed_i && divisor_i[DW-1]) ? -divisor_i : divisor_i;
        rem   <= '0;
        step  <= '0;
        zero  <= (divisor_i == '0);
        // A zero divisor skips the loop; the caller reports the error.
        run   <= (divisor_i != '0);
        fix   <= (divisor_i == '0);
      end else if (run) begin
        quo  <= {quo[2*DW-2:0], fits};
        rem  <= fits ? DW'(shifted - {1'b0, dsr}) : shifted[DW-1:0];
        step <= step + CW'(1);
        if (step == LAST_STEP) begin
          run <= 1'b0;
          fix <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    q_s = neg_q ? -quo : quo;
    r_s = neg_r ? -rem : rem;
    // The alternate form rounds towards minus infinity.
    if (alt && (rem != '0) && (neg_r != neg_d)) begin
      q_s = q_s - 1'b1;
      r_s = r_s + (neg_d ? -dsr : dsr);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o      <= 1'b0;
      zero_div_o  <= 1'b0;
      quotient_o  <= '0;
      remainder_o <= '0;
    end else begin
      done_o <= fix;
      if (fix) begin
        zero_div_o  <= zero;
        quotient_o  <= q_s;
        remainder_o <= r_s;
      end
    end
  end

endmodule

// ### hdl/ida_arith_unit.sv
`timescale 1ns/1ps

// Overview of operation
// - Magnitude replaces destination with its absolute value.
// - Carry add sums operands and carry flag.
// - Plain add ignores incoming carry.
// - Extended add sign-extends source to 32 bits.
// - Destination takes lower bound when below it.
// - Compare subtracts, keeps flags, discards difference.
// - Extended compare on 32-bit sign-extended source.
// - Decimal add includes carry flag.
// - Decimal add ignores incoming carry.
// - Decimal subtract removes source and borrow.
// - Signed divide: quotient low, remainder high.
// - Unsigned divide uses the same register pair.
// - Flag bit write touches carry only if chosen.
module ida_arith_unit #(
  parameter int unsigned DW = ida_pkg::DATA_W,
  parameter int unsigned RW = ida_pkg::OPND_W
) (
  input  wire logic              clk_i,                   // Core clock, 100 MHz
  input  wire logic              rst_b_i,                 // Asynchronous reset, active low
  input  wire logic              start_i,                 // One-cycle operation request
  input  wire ida_pkg::ida_req_t req_i,                   // Operation and operands
  input  wire ida_pkg::ida_flags_t flags_i,               // Current flag register
  output logic                   busy_o,                  // Division in progress
  output logic                   done_o,                  // One-cycle completion pulse
  output logic                   dest_we_o,               // Write result to destination
  output logic [DW-1:0]          result_o,                // Destination result
  output ida_pkg::ida_flags_t    flags_o,                 // New flag register value
  output logic                   pair_we_o,               // Write the division pair
  output logic [RW-1:0]          low_result_register_o,   // Quotient; byte size puts the remainder in its high byte
  output logic [RW-1:0]          high_result_register_o   // Remainder
);

  // ------------------------------------------------------------------
  // Width helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] extend(input logic [31:0] v, input logic [1:0] w,
                                         input logic sgn);
    logic [31:0] r;
    r = v;
    case (w)
      ida_pkg::WID_8:  r = {{24{sgn & v[7]}}, v[7:0]};
      ida_pkg::WID_16: r = {{16{sgn & v[15]}}, v[15:0]};
      default:         r = v;
    endcase
    return r;
  endfunction

  function automatic logic top_bit(input logic [32:0] v, input logic [1:0] w,
                                   input logic carry);
    logic r;
    r = 1'b0;
    case (w)
      ida_pkg::WID_8:  r = carry ? v[8]  : v[7];
      ida_pkg::WID_16: r = carry ? v[16] : v[15];
      default:         r = carry ? v[32] : v[31];
    endcase
    return r;
  endfunction

  ida_pkg::ida_state_t state;
  ida_pkg::ida_op_t    op;
  logic [1:0]          wid;
  logic [31:0]         src_x;
  logic [31:0]         dst_x;
  logic [31:0]         src_s;
  logic [31:0]         dst_s;
  logic [31:0]         lo_b;
  logic [31:0]         hi_b;
  logic [31:0]         a_op;
  logic [31:0]         b_op;
  logic                cin;
  logic                sub;
  logic [32:0]         raw;
  logic                take;
  logic [RW-1:0]       bcd_sum;
  logic [3:0]          bcd_carry;
  logic                bcd_cout;
  logic [31:0]         next_result;
  ida_pkg::ida_flags_t next_flags;
  logic                next_we;
  logic                is_div;
  logic                div_signed;
  logic                div_done;
  logic                div_zero;
  logic [2*RW-1:0]     div_quo;
  logic [RW-1:0]       div_rem;
  logic [2*RW-1:0]     dividend;
  logic [RW-1:0]       divisor;
  logic                div_sz;
  logic                div_sgn;
  logic [31:0]         q_ext;
  logic                q_fits;

  assign op    = req_i.op;
  assign take  = start_i && (state == ida_pkg::ida_st_idle);
  assign wid   = (op == ida_pkg::ida_extended_sum_op || op == ida_pkg::ida_extended_compare_op)
                 ? ida_pkg::WID_32
                 : (req_i.size == ida_pkg::SIZE_WORD ? ida_pkg::WID_16 : ida_pkg::WID_8);
  // The extended forms take a narrow source sign-extended to 32 bits.
  assign src_s = extend(req_i.src, (wid == ida_pkg::WID_32) ? {1'b0, req_i.size} : wid,
                        1'b1);
  assign src_x = extend(src_s, wid, 1'b0);
  assign dst_x = extend(req_i.dest, wid, 1'b0);
  assign dst_s = extend(req_i.dest, wid, 1'b1);
  assign lo_b  = extend(req_i.src, wid, 1'b1);
  assign hi_b  = extend(req_i.src2, wid, 1'b1);

  // ------------------------------------------------------------------
  // Shared binary adder
  // ------------------------------------------------------------------
  always_comb begin
    a_op = dst_x;
    b_op = src_x;
    cin  = 1'b0;
    sub  = 1'b0;
    case (op)
      ida_pkg::ida_magnitude_op: begin
        a_op = 32'h0000_0000;
        b_op = dst_x;
        sub  = dst_s[31];
        if (!dst_s[31]) begin
          a_op = dst_x;
          b_op = 32'h0000_0000;
        end
      end
      ida_pkg::ida_sum_with_carry_op:       cin = flags_i.c;
      ida_pkg::ida_carry_only_increment_op: begin
        b_op = 32'h0000_0000;
        cin  = flags_i.c;
      end
      ida_pkg::ida_plain_sum_op:            cin = 1'b0;
      ida_pkg::ida_extended_sum_op:         cin = 1'b0;
      ida_pkg::ida_compare_op:              sub = 1'b1;
      ida_pkg::ida_extended_compare_op:     sub = 1'b1;
      default: begin
        a_op = dst_x;
        b_op = src_x;
      end
    endcase
    raw = sub ? ({1'b0, a_op} - {1'b0, b_op} - {32'h0, cin})
              : ({1'b0, a_op} + {1'b0, b_op} + {32'h0, cin});
  end

  // ------------------------------------------------------------------
  // Packed decimal adder
  // ------------------------------------------------------------------
  ida_bcd #(
    .DIGITS (ida_pkg::BCD_DIGITS)
  ) u_bcd (
    .a_i     (req_i.dest[RW-1:0]),
    .b_i     ((op == ida_pkg::ida_bcd_sum_with_carry_op ||
               op == ida_pkg::ida_bcd_sum_op ||
               op == ida_pkg::ida_bcd_difference_with_borrow_op) ? req_i.src[RW-1:0] : '0),
    .cin_i   ((op != ida_pkg::ida_bcd_sum_op) && flags_i.c),
    .sub_i   (op == ida_pkg::ida_bcd_difference_with_borrow_op),
    .sum_o   (bcd_sum),
    .carry_o (bcd_carry)
  );

  assign bcd_cout = (wid == ida_pkg::WID_8) ? bcd_carry[1] : bcd_carry[3];

  // ------------------------------------------------------------------
  // Result and flag selection
  // ------------------------------------------------------------------
  always_comb begin
    next_result = dst_x;
    next_flags  = flags_i;
    next_we     = 1'b0;
    case (op)
      ida_pkg::ida_magnitude_op,
      ida_pkg::ida_sum_with_carry_op,
      ida_pkg::ida_carry_only_increment_op,
      ida_pkg::ida_plain_sum_op,
      ida_pkg::ida_extended_sum_op,
      ida_pkg::ida_compare_op,
      ida_pkg::ida_extended_compare_op: begin
        next_result  = extend(raw[31:0], wid, 1'b0);
        // Compares only report; the difference never reaches the destination.
        next_we      = (op != ida_pkg::ida_compare_op) &&
                       (op != ida_pkg::ida_extended_compare_op);
        next_flags.c = top_bit(raw, wid, 1'b1);
        next_flags.s = top_bit({1'b0, next_result}, wid, 1'b0);
        next_flags.z = (next_result == 32'h0000_0000);
        next_flags.o = sub
          ? (top_bit({1'b0, a_op}, wid, 1'b0) != top_bit({1'b0, b_op}, wid, 1'b0)) &&
            (top_bit({1'b0, next_result}, wid, 1'b0) != top_bit({1'b0, a_op}, wid, 1'b0))
          : (top_bit({1'b0, a_op}, wid, 1'b0) == top_bit({1'b0, b_op}, wid, 1'b0)) &&
            (top_bit({1'b0, next_result}, wid, 1'b0) != top_bit({1'b0, a_op}, wid, 1'b0));
      end
      ida_pkg::ida_range_limit_op: begin
        next_we = 1'b1;
        if ($signed(lo_b) > $signed(dst_s)) begin
          next_result = extend(lo_b, wid, 1'b0);
        end else if ($signed(dst_s) > $signed(hi_b)) begin
          next_result = extend(hi_b, wid, 1'b0);
        end
      end
      ida_pkg::ida_bcd_sum_with_carry_op,
      ida_pkg::ida_bcd_sum_op,
      ida_pkg::ida_bcd_difference_with_borrow_op: begin
        next_result  = extend({16'h0000, bcd_sum}, wid, 1'b0);
        next_we      = 1'b1;
        next_flags.c = bcd_cout;
        next_flags.s = top_bit({1'b0, next_result}, wid, 1'b0);
        next_flags.z = (next_result == 32'h0000_0000);
      end
      ida_pkg::ida_flag_bit_write_op: begin
        // Any other flag bit chosen leaves carry as it was.
        next_flags[req_i.bit_index] = req_i.bit_value;
      end
      default: begin
        next_result = dst_x;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Division pair
  // ------------------------------------------------------------------
  assign is_div     = (op == ida_pkg::ida_signed_quotient_op) ||
                      (op == ida_pkg::ida_unsigned_quotient_op) ||
                      (op == ida_pkg::ida_signed_quotient_alt_op);
  assign div_signed = (op != ida_pkg::ida_unsigned_quotient_op);
  assign dividend   = (req_i.size == ida_pkg::SIZE_WORD)
    ? {req_i.high_result_register, req_i.low_result_register}
    : extend({16'h0000, req_i.high_result_register[7:0], req_i.low_result_register[7:0]},
             ida_pkg::WID_16, div_signed);
  assign divisor    = RW'(extend(req_i.src, wid, div_signed));

  ida_divider #(
    .DW (RW)
  ) u_div (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .start_i     (take && is_div),
    .signed_i    (div_signed),
    .alt_i       (op == ida_pkg::ida_signed_quotient_alt_op),
    .dividend_i  (dividend),
    .divisor_i   (divisor),
    .done_o      (div_done),
    .zero_div_o  (div_zero),
    .quotient_o  (div_quo),
    .remainder_o (div_rem)
  );

  // A quotient that does not fit the operand size is an overflow, not a write.
  assign q_ext  = extend(div_quo, div_sz ? ida_pkg::WID_16 : ida_pkg::WID_8, div_sgn);
  assign q_fits = (q_ext == div_quo) && !div_zero;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= ida_pkg::ida_st_idle;
      div_sz  <= ida_pkg::SIZE_BYTE;
      div_sgn <= 1'b0;
    end else begin
      case (state)
        ida_pkg::ida_st_idle: begin
          if (take && is_div) begin
            state   <= ida_pkg::ida_st_div_wait;
            div_sz  <= req_i.size;
            div_sgn <= div_signed;
          end
        end
        ida_pkg::ida_st_div_wait: begin
          if (div_done) begin
            state <= ida_pkg::ida_st_idle;
          end
        end
        default: state <= ida_pkg::ida_st_idle;
      endcase
    end
  end

  assign busy_o = (state != ida_pkg::ida_st_idle);

  // ------------------------------------------------------------------
  // Registered answers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o                 <= 1'b0;
      dest_we_o              <= 1'b0;
      pair_we_o              <= 1'b0;
      result_o               <= ida_pkg::RESULT_RESET;
      flags_o                <= ida_pkg::FLAGS_RESET;
      low_result_register_o  <= '0;
      high_result_register_o <= '0;
    end else begin
      done_o    <= 1'b0;
      dest_we_o <= 1'b0;
      pair_we_o <= 1'b0;
      if (take && !is_div) begin
        done_o    <= 1'b1;
        dest_we_o <= next_we;
        result_o  <= next_result;
        flags_o   <= next_flags;
      end else if (take && is_div) begin
        flags_o <= flags_i;
      end else if ((state == ida_pkg::ida_st_div_wait) && div_done) begin
        done_o    <= 1'b1;
        pair_we_o <= q_fits;
        flags_o.o <= !q_fits;
        if (q_fits) begin
          low_result_register_o  <= div_sz ? div_quo[RW-1:0]
                                           : {div_rem[7:0], div_quo[7:0]};
          high_result_register_o <= div_sz ? div_rem : {8'h00, div_rem[7:0]};
        end
      end
    end
  end

endmodule

// ### dv/ida_chk_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks for the arithmetic unit
// ----------------------------------------------------------------
module ida_chk (
  input wire logic                clk_i,     // Core clock
  input wire logic                rst_b_i,   // Reset, active low
  input wire logic                start_i,   // Request pulse
  input wire ida_pkg::ida_req_t   req_i,     // Operands
  input wire ida_pkg::ida_flags_t flags_i,   // Flags in
  input wire logic                busy_o,    // Division running
  input wire logic                done_o,    // Completion pulse
  input wire logic                dest_we_o, // Destination write
  input wire logic                pair_we_o, // Pair write
  input wire logic [31:0]         result_o,  // Result
  input wire ida_pkg::ida_flags_t flags_o    // Flags out
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ida_pkg::ida_req_t   rq;
  ida_pkg::ida_flags_t fl;
  logic                tk;
  logic                dv;
  // Operands are kept one cycle so a result can be tied to its request.
  always_ff @(posedge clk_i) begin
    rq <= req_i;
    fl <= flags_i;
  end
  always_comb tk = start_i && !busy_o;
  always_comb dv = req_i.op >= 4'hB && req_i.op <= 4'hD;
  chk_single_done: assert property (tk && !dv |=> done_o && !busy_o)
    else $error("single op not done");
  chk_div_busy: assert property (tk && dv |=> busy_o && !done_o)
    else $error("division did not hold busy");
  chk_div_bound: assert property (tk && dv |-> ##[3:35] done_o)
    else $error("division too slow");
  chk_pair_alone: assert property (pair_we_o |-> done_o && !dest_we_o)
    else $error("stray pair write");
  chk_cmp_no_write: assert property (tk && (req_i.op == ida_pkg::ida_compare_op ||
      req_i.op == ida_pkg::ida_extended_compare_op) |=> done_o && !dest_we_o)
    else $error("compare wrote dest");
  chk_plain_sum: assert property (tk && req_i.op == ida_pkg::ida_plain_sum_op && req_i.size
      |=> result_o == {16'h0000, rq.src[15:0] + rq.dest[15:0]})
    else $error("plain sum wrong");
  chk_carry_sum: assert property (tk && req_i.op == ida_pkg::ida_sum_with_carry_op && req_i.size
      |=> result_o == {16'h0000, rq.src[15:0] + rq.dest[15:0] + {15'h0, fl.c}})
    else $error("carry sum wrong");
  chk_ext_sum: assert property (tk && req_i.op == ida_pkg::ida_extended_sum_op && req_i.size
      |=> result_o == rq.dest + {{16{rq.src[15]}}, rq.src[15:0]})
    else $error("extended sum wrong");
  chk_flag_carry: assert property (tk && req_i.op == ida_pkg::ida_flag_bit_write_op &&
      req_i.bit_index != 3'h0 |=> flags_o.c == fl.c)
    else $error("carry changed");
endmodule
bind ida_arith_unit ida_chk u_chk (.clk_i, .rst_b_i, .start_i, .req_i, .flags_i, .busy_o,
  .done_o, .dest_we_o, .pair_we_o, .result_o, .flags_o);

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic        div;
    logic        chk;
    logic [2:0]  fpos;
    logic        fval;
    logic        we;
    logic [31:0] data;
  } ida_exp_t;
  logic                clk_i = 1'b0;
  logic                rst_b_i = 1'b0;
  logic                start_i = 1'b0;
  ida_pkg::ida_req_t   req_i = '0;
  ida_pkg::ida_flags_t flags_i = '0;
  logic                busy_o, done_o, dest_we_o, pair_we_o;
  logic [31:0]         result_o, rnd = 32'hC379;
  ida_pkg::ida_flags_t flags_o;
  logic [15:0]         lo_o, hi_o, a, b, d;
  logic [16:0]         s;
  logic                c;
  ida_exp_t            exp_q[$];
  ida_exp_t            e;
  int                  err_total = 0, checked = 0, cyc = 0, q, r;
  ida_arith_unit dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .req_i(req_i),
    .flags_i(flags_i), .busy_o(busy_o), .done_o(done_o), .dest_we_o(dest_we_o),
    .result_o(result_o), .flags_o(flags_o), .pair_we_o(pair_we_o),
    .low_result_register_o(lo_o), .high_result_register_o(hi_o));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic ida_exp_t ex(input logic chk, v, we, input logic [31:0] dt);
    return '{1'b0, chk, 3'h0, v, we, dt};
  endfunction
  // Nibble-wise decimal model; returns the top carry or borrow above the digits.
  function automatic logic [16:0] bcd(input logic [15:0] x, y, input logic ci, sub);
    int t;
    for (int k = 0; k < 4; k++) begin
      t = sub ? int'(x[4*k+:4]) - int'(y[4*k+:4]) - ci : int'(x[4*k+:4]) + int'(y[4*k+:4]) + ci;
      ci = sub ? t < 0 : t > 9;
      x[4*k+:4] = 4'(sub ? (t < 0 ? t + 10 : t) : (t > 9 ? t - 10 : t));
    end
    return {ci, x};
  endfunction
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic issue(input ida_pkg::ida_op_t op, input logic [31:0] src, src2, dst,
                       input logic [15:0] hi, lo, input logic [7:0] f, input ida_exp_t x);
    @(posedge clk_i);
    start_i <= 1'b1;
    req_i <= '{op, 1'b1, src, src2, dst, hi, lo, src[2:0], src[3]};
    flags_i <= f;
    exp_q.push_back(x);
  endtask
  // Start is left high for n edges; while busy those extra starts must be ignored.
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    start_i <= 1'b0;
  endtask
  task automatic div_run(input ida_pkg::ida_op_t op, input logic [15:0] dd, hi, lo, q, r,
                         input logic ok);
    issue(op, dd, 0, 0, hi, lo, 8'h00, '{1'b1, 1'b1, 3'h5, ~ok, ok, {r, q}});
    idle(3);
    for (int k = 0; k < 40 && done_o !== 1'b1; k++) @(negedge clk_i);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Result watcher and hang guard
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0)
        check(1'b1, 1'b0);
      else begin
        e = exp_q.pop_front();
        check(e.div ? pair_we_o : dest_we_o, e.we);
        if (e.we || e.div) check(e.div ? {hi_o, lo_o} : result_o, e.data);
        if (e.chk) check(flags_o[e.fpos], e.fval);
      end
    end
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a = rnd[15:0];
      b = rnd[31:16];
      c = rnd[7];
      s = a + b;
      issue(ida_pkg::ida_plain_sum_op, b, 0, a, 0, 0, 8'h01, ex(1, s[16], 1, s[15:0]));
      s = a + b + c;
      issue(ida_pkg::ida_sum_with_carry_op, b, 0, a, 0, 0, c, ex(1, s[16], 1, s[15:0]));
      s = a + c;
      issue(ida_pkg::ida_carry_only_increment_op, 0, 0, a, 0, 0, c, ex(0, 0, 1, s[15:0]));
      issue(ida_pkg::ida_magnitude_op, 0, 0, a, 0, 0, 0, ex(0, 0, 1, {16'h0, a[15] ? -a : a}));
      issue(ida_pkg::ida_extended_sum_op, b, 0, rnd, 0, 0, 0, ex(0, 0, 1, rnd + {{16{b[15]}}, b}));
      issue(ida_pkg::ida_compare_op, b, 0, a, 0, 0, 0, ex(1, a < b, 0, 0));
      issue(ida_pkg::ida_extended_compare_op, b, 0, rnd, 0, 0, 0, ex(1, rnd < {{16{b[15]}}, b}, 0, 0));
      d = i[0] ? a & 16'h00FF : a;
      issue(ida_pkg::ida_range_limit_op, 16'hFF9C, 16'h0100, d, 0, 0, 0, ex(0, 0, 1,
        $signed(d) < -100 ? 16'hFF9C : $signed(d) > 256 ? 16'h0100 : d));
      for (int k = 0; k < 4; k++) a[4*k+:4] = 4'(a[4*k+:4] % 10);
      for (int k = 0; k < 4; k++) b[4*k+:4] = 4'(b[4*k+:4] % 10);
      s = bcd(a, b, c, 0);
      issue(ida_pkg::ida_bcd_sum_with_carry_op, b, 0, a, 0, 0, c, ex(1, s[16], 1, s[15:0]));
      s = bcd(a, b, 0, 0);
      issue(ida_pkg::ida_bcd_sum_op, b, 0, a, 0, 0, 8'h01, ex(1, s[16], 1, s[15:0]));
      s = bcd(a, b, c, 1);
      issue(ida_pkg::ida_bcd_difference_with_borrow_op, b, 0, a, 0, 0, c, ex(1, s[16], 1, s[15:0]));
      issue(ida_pkg::ida_flag_bit_write_op, {c, i[2:0]}, 0, 0, 0, 0, ~c, ex(1, i == 0 ? c : ~c, 0, 0));
    end
    idle(1);
    $display("single-cycle operations finished");
    d = {8'h00, b[7:0]} | 16'h0001;
    a = a | 16'h8000;
    q = int'($signed(a)) / int'(d);
    r = int'($signed(a)) % int'(d);
    div_run(ida_pkg::ida_signed_quotient_op, d, 16'hFFFF, a, q, r, 1);
    if (r != 0) begin
      q = q - 1;
      r = r + int'(d);
    end
    div_run(ida_pkg::ida_signed_quotient_alt_op, d, 16'hFFFF, a, q, r, 1);
    q = int'({d - 16'h0001, a}) / int'(d);
    r = int'({d - 16'h0001, a}) % int'(d);
    div_run(ida_pkg::ida_unsigned_quotient_op, d, d - 16'h0001, a, q, r, 1);
    div_run(ida_pkg::ida_unsigned_quotient_op, 0, 16'h0000, a, q, r, 0);
    repeat (3) @(posedge clk_i);
    check(exp_q.size(), 0);
    $display("division operations finished");
    wrap_up();
  end
endmodule
